// ---- rtl/psss_pkg.sv ----
// Constants, register map and types of the power-state startup and shutdown controller.
// Assumes one always-on 100 MHz clock and a plain 8-bit address, 16-bit data register port.
package psss_pkg;

  // Clock rate and the times that the controller measures.
  localparam int LP_CLK_HZ = 100_000_000;
  localparam int LP_QUAL_MS = 40;
  localparam int LP_QUAL_CYC = LP_QUAL_MS * (LP_CLK_HZ / 1000);
  localparam int LP_HOLD_LONG_S = 10;
  localparam int LP_HOLD_LONG_CYC = LP_HOLD_LONG_S * LP_CLK_HZ;
  localparam int LP_HOLD_SHORT_S = 5;
  localparam int LP_HOLD_SHORT_CYC = LP_HOLD_SHORT_S * LP_CLK_HZ;
  localparam int LP_SLOT_US = 1280;
  localparam int LP_SLOT_CYC = LP_SLOT_US * (LP_CLK_HZ / 1_000_000);
  localparam int LP_CNT_W = 32;

  // Register port.
  localparam int LP_ADDR_W = 8;
  localparam int LP_DATA_W = 16;
  localparam logic [LP_ADDR_W-1:0] LP_REG_CTRL = 8'h03;
  localparam logic [LP_ADDR_W-1:0] LP_REG_STATUS = 8'h1f;
  localparam logic [LP_ADDR_W-1:0] LP_REG_MASK = 8'h27;
  localparam logic [LP_ADDR_W-1:0] LP_REG_CFG = 8'h40;
  localparam logic [LP_ADDR_W-1:0] LP_REG_STATE = 8'h41;
  localparam logic [LP_ADDR_W-1:0] LP_REG_SLOT0 = 8'h50;

  // Control register fields and reset values.
  localparam int LP_CTRL_ON_BIT = 15;
  localparam int LP_CTRL_HOLD_BIT = 3;
  localparam int LP_CTRL_POL_BIT = 1;
  localparam logic LP_CHIP_ON_RST = 1'b0;
  localparam logic LP_HOLD_SEL_RST = 1'b0;
  localparam logic LP_POL_RST = 1'b1;

  // Configuration register fields.
  localparam int LP_CFG_W = 6;
  localparam int LP_CFG_ALARM_EN = 0;
  localparam int LP_CFG_USB_SUSP = 1;
  localparam int LP_CFG_WAKE_LOW = 2;
  localparam int LP_CFG_UP_LOW = 3;
  localparam int LP_CFG_DOWN_LOW = 4;
  localparam int LP_CFG_HIB = 5;
  localparam logic [LP_CFG_W-1:0] LP_CFG_RST = 6'h00;

  // Wake cause status and mask.
  localparam int LP_ST_W = 7;
  localparam int LP_ST_OFF = 6;
  localparam int LP_ST_HIB = 5;
  localparam int LP_ST_CONV = 4;
  localparam int LP_ST_WDOG = 3;
  localparam int LP_ST_UP = 2;
  localparam int LP_ST_BTN = 1;
  localparam int LP_ST_WAKE = 0;
  localparam logic [LP_ST_W-1:0] LP_MASK_RST = 7'h00;

  // Sequencer.
  localparam int LP_NUM_SUPPLY = 11;
  localparam int LP_SLOT_W = 4;
  localparam logic [LP_SLOT_W-1:0] LP_LAST_SLOT = 4'hd;
  localparam logic [LP_SLOT_W-1:0] LP_SLOT_TAB_RST = 4'h0;
  localparam logic [3:0] LP_WDOG_PRIOR_FAULTS = 4'h7;

  // Trigger qualifier channels.
  localparam int LP_NUM_TRIG = 5;
  localparam int LP_TRG_BTN = 0;
  localparam int LP_TRG_BTN_LONG = 1;
  localparam int LP_TRG_WAKE = 2;
  localparam int LP_TRG_UP = 3;
  localparam int LP_TRG_DOWN = 4;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_SEQ = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_HIB = 2'b11
  } psss_state_t;

endpackage : psss_pkg

// ---- rtl/psss_trig_if.sv ----
// Connection between the controller and one trigger duration qualifier.
// Assumes the level arrives synchronous to the system clock.
interface psss_trig_if;
  import psss_pkg::*;
  logic raw;
  logic act_low;
  logic [LP_CNT_W-1:0] limit;
  logic held;
  logic fire;
  modport src (output raw, output act_low, output limit, input held, input fire);
  modport qual (input raw, input act_low, input limit, output held, output fire);
endinterface : psss_trig_if

// ---- rtl/psss_trig_qual.sv ----
// Trigger duration qualifier: reports a level held longer than a cycle limit.
// Assumes the input is synchronous and the limit is at least one.
module psss_trig_qual
  import psss_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  psss_trig_if.qual trg
);

  logic [LP_CNT_W-1:0] cnt_ff;
  logic held_d_ff;
  logic asserted;

  assign asserted = trg.raw ^ trg.act_low;
  // Comparing with >= keeps a shortened limit from being stepped over.
  // A hold already reported stays held if the limit is raised, so one hold never gives two events.
  assign trg.held = asserted && ((cnt_ff >= trg.limit) || held_d_ff);
  assign trg.fire = trg.held && !held_d_ff;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      cnt_ff <= '0;
    else if (!asserted)
      cnt_ff <= '0;
    else if (cnt_ff < trg.limit)
      cnt_ff <= cnt_ff + 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      held_d_ff <= 1'b0;
    else
      held_d_ff <= trg.held;
  end

  property p_release_clears;
    @(posedge i_clk_sys) disable iff (!i_nrst) !asserted |=> (cnt_ff == '0) && !trg.held;
  endproperty
  a_release_clears: assert property (p_release_clears) else $error("Counter kept after release.");

  property p_fire_once;
    @(posedge i_clk_sys) disable iff (!i_nrst) trg.fire |=> !trg.fire && (trg.held || !asserted);
  endproperty
  a_fire_once: assert property (p_fire_once) else $error("Qualified event repeated.");

endmodule : psss_trig_qual

// ---- rtl/psss_ctrl.sv ----
// Power-state controller: startup and shutdown events, supply sequencing, wake cause status.
// Assumes synchronous pins and a host on the plain register port; control, configuration and mask registers are lost in OFF.
// Operation
// - OFF or HIBERNATE to ACTIVE on startup.
// - Button held over 40 ms starts.
// - Wake GPIO held over 40 ms starts.
// - Power-up GPIO held over 40 ms starts.
// - RTC alarm starts only when enabled.
// - Adaptor or USB rising edge starts.
// - Startup needs supply above threshold.
// - USB start picks battery or USB trickle.
// - Battery arrival never starts the device.
// - Status bits for start from OFF/HIBERNATE.
// - Status bits for fault and watchdog resets.
// - Status bits for qualified trigger presses.
// - Status set on rising edge, clear on read.
// - Mask bit one keeps its status off the interrupt.
// - Wake interrupt on any unmasked status.
// - Sequencer runs fourteen slots; each of eleven supplies picks one.
// - Advance after 1.28 ms and supplies good.
// - Shutdown events move to OFF.
// - Startup sets on bit; writing zero shuts down.
// - Power-down GPIO held over 40 ms stops.
// - Button held 10 s or 5 s stops.
// - Watchdog stops only after seven faults.
// - Button polarity: one is active low, reset one.
// - Hold select: zero 10 s, one 5 s.
// - Shutdown resets controls, asserts reset, enters OFF.
module psss_ctrl
  import psss_pkg::*;
#(
  parameter logic [LP_CNT_W-1:0] P_QUAL_CYC = LP_CNT_W'(LP_QUAL_CYC),
  parameter logic [LP_CNT_W-1:0] P_HOLD_LONG_CYC = LP_CNT_W'(LP_HOLD_LONG_CYC),
  parameter logic [LP_CNT_W-1:0] P_HOLD_SHORT_CYC = LP_CNT_W'(LP_HOLD_SHORT_CYC),
  parameter logic [LP_CNT_W-1:0] P_SLOT_CYC = LP_CNT_W'(LP_SLOT_CYC)
)
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [LP_ADDR_W-1:0] i_addr,
  input wire logic [LP_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [LP_DATA_W-1:0] o_rdata,
  input wire logic i_button,
  input wire logic i_gpio_wake,
  input wire logic i_gpio_power_up_input,
  input wire logic i_gpio_power_down_input,
  input wire logic i_rtc_alarm,
  input wire logic i_adaptor_sense,
  input wire logic i_usb_sense,
  input wire logic i_supply_above_threshold,
  input wire logic i_conv_fault_reset,
  input wire logic i_wdog_reset,
  input wire logic i_wdog_timeout,
  input wire logic [3:0] i_prior_fault_count,
  input wire logic i_fault_shutdown,
  input wire logic i_thermal_shutdown,
  input wire logic [LP_NUM_SUPPLY-1:0] i_supply_good,
  output logic [LP_NUM_SUPPLY-1:0] o_supply_en,
  output logic o_sel_battery,
  output logic o_sel_usb,
  output logic o_usb_trickle_100ma,
  output logic o_wake_first_level_irq,
  output logic o_sys_reset_n,
  output logic [1:0] o_power_state
);

  psss_state_t state_ff;
  psss_state_t nxt_state;
  logic chip_on_ff;
  logic hold_sel_ff;
  logic pol_ff;
  logic [LP_CFG_W-1:0] cfg_ff;
  logic [LP_ST_W-1:0] status_ff;
  logic [LP_ST_W-1:0] mask_ff;
  logic [LP_ST_W-1:0] set_v;
  logic [LP_SLOT_W-1:0] slot_tab_ff [LP_NUM_SUPPLY];
  logic [LP_SLOT_W-1:0] slot_ff;
  logic [LP_SLOT_W-1:0] slot_idx;
  logic [LP_CNT_W-1:0] tmr_ff;
  logic [LP_NUM_SUPPLY-1:0] slot_hit;
  logic [LP_NUM_SUPPLY-1:0] en_ff;
  logic [LP_DATA_W-1:0] rdata_ff;
  logic [LP_DATA_W-1:0] rd_val;
  logic alarm_d_ff;
  logic adaptor_d_ff;
  logic usb_d_ff;
  logic conv_d_ff;
  logic wdog_d_ff;
  logic sel_bat_ff;
  logic sel_usb_ff;
  logic trickle_ff;
  logic sys_reset_n_ff;
  logic ev_alarm;
  logic ev_adaptor;
  logic ev_usb;
  logic start_ev;
  logic start_ok;
  logic sw_off;
  logic wdog_stop;
  logic stop_ev;
  logic going_off;
  logic slot_ok;
  logic seq_done;
  logic wr_ctrl;
  logic wr_cfg;
  logic rd_status;

  psss_trig_if u_trg [LP_NUM_TRIG] ();

  assign u_trg[LP_TRG_BTN].raw = i_button;
  assign u_trg[LP_TRG_BTN].act_low = pol_ff;
  assign u_trg[LP_TRG_BTN].limit = P_QUAL_CYC;
  assign u_trg[LP_TRG_BTN_LONG].raw = i_button;
  assign u_trg[LP_TRG_BTN_LONG].act_low = pol_ff;
  assign u_trg[LP_TRG_BTN_LONG].limit = hold_sel_ff ? P_HOLD_SHORT_CYC : P_HOLD_LONG_CYC;
  assign u_trg[LP_TRG_WAKE].raw = i_gpio_wake;
  assign u_trg[LP_TRG_WAKE].act_low = cfg_ff[LP_CFG_WAKE_LOW];
  assign u_trg[LP_TRG_WAKE].limit = P_QUAL_CYC;
  assign u_trg[LP_TRG_UP].raw = i_gpio_power_up_input;
  assign u_trg[LP_TRG_UP].act_low = cfg_ff[LP_CFG_UP_LOW];
  assign u_trg[LP_TRG_UP].limit = P_QUAL_CYC;
  assign u_trg[LP_TRG_DOWN].raw = i_gpio_power_down_input;
  assign u_trg[LP_TRG_DOWN].act_low = cfg_ff[LP_CFG_DOWN_LOW];
  assign u_trg[LP_TRG_DOWN].limit = P_QUAL_CYC;

  generate
    for (genvar g = 0; g < LP_NUM_TRIG; g++)
    begin : g_trig
      psss_trig_qual u_qual (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .trg(u_trg[g])
      );
    end
  endgenerate

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      alarm_d_ff <= 1'b0;
      adaptor_d_ff <= 1'b0;
      usb_d_ff <= 1'b0;
      conv_d_ff <= 1'b0;
      wdog_d_ff <= 1'b0;
    end
    else
    begin
      alarm_d_ff <= i_rtc_alarm;
      adaptor_d_ff <= i_adaptor_sense;
      usb_d_ff <= i_usb_sense;
      conv_d_ff <= i_conv_fault_reset;
      wdog_d_ff <= i_wdog_reset;
    end
  end

  assign ev_alarm = i_rtc_alarm && !alarm_d_ff && cfg_ff[LP_CFG_ALARM_EN];
  assign ev_adaptor = i_adaptor_sense && !adaptor_d_ff;
  assign ev_usb = i_usb_sense && !usb_d_ff;
  assign start_ev = i_supply_above_threshold && (u_trg[LP_TRG_BTN].fire || u_trg[LP_TRG_WAKE].fire
    || u_trg[LP_TRG_UP].fire || ev_alarm || ev_adaptor || ev_usb);

  assign wr_ctrl = i_wr && (i_addr == LP_REG_CTRL);
  assign wr_cfg = i_wr && (i_addr == LP_REG_CFG);
  assign rd_status = i_rd && (i_addr == LP_REG_STATUS);

  assign sw_off = wr_ctrl && !i_wdata[LP_CTRL_ON_BIT] && chip_on_ff;
  assign wdog_stop = i_wdog_timeout && (i_prior_fault_count >= LP_WDOG_PRIOR_FAULTS);
  assign stop_ev = sw_off || u_trg[LP_TRG_DOWN].fire || u_trg[LP_TRG_BTN_LONG].fire || wdog_stop
    || i_fault_shutdown || i_thermal_shutdown;
  assign start_ok = start_ev && !stop_ev;
  assign going_off = (state_ff != ST_OFF) && stop_ev;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF:
        if (start_ok)
          nxt_state = ST_SEQ;
      ST_SEQ:
        if (stop_ev)
          nxt_state = ST_OFF;
        else if (seq_done)
          nxt_state = ST_ACTIVE;
      ST_ACTIVE:
        if (stop_ev)
          nxt_state = ST_OFF;
        else if (cfg_ff[LP_CFG_HIB])
          nxt_state = ST_HIB;
      ST_HIB:
        if (stop_ev)
          nxt_state = ST_OFF;
        else if (start_ok || !cfg_ff[LP_CFG_HIB])
          nxt_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      state_ff <= ST_OFF;
    else
      state_ff <= nxt_state;
  end

  // Slot entries of 14 or 15 are never reached, which leaves that supply off.
  generate
    for (genvar s = 0; s < LP_NUM_SUPPLY; s++)
    begin : g_slot
      assign slot_hit[s] = (slot_tab_ff[s] == slot_ff);
      always_ff @(posedge i_clk_sys)
      begin
        if (!i_nrst)
          slot_tab_ff[s] <= LP_SLOT_TAB_RST;
        else if (i_wr && (i_addr == LP_REG_SLOT0 + s))
          slot_tab_ff[s] <= i_wdata[LP_SLOT_W-1:0];
      end
    end
  endgenerate

  assign slot_ok = &(~slot_hit | i_supply_good);
  assign seq_done = (state_ff == ST_SEQ) && (tmr_ff >= P_SLOT_CYC) && slot_ok && (slot_ff == LP_LAST_SLOT);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      slot_ff <= '0;
      tmr_ff <= '0;
    end
    else if (state_ff != ST_SEQ)
    begin
      slot_ff <= '0;
      tmr_ff <= '0;
    end
    else if (tmr_ff < P_SLOT_CYC)
      tmr_ff <= tmr_ff + 1'b1;
    else if (slot_ok && (slot_ff != LP_LAST_SLOT))
    begin
      slot_ff <= slot_ff + 1'b1;
      tmr_ff <= '0;
    end
  end

  // A supply stays enabled once its slot has come, until the device goes off.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      en_ff <= '0;
    else if (nxt_state == ST_OFF)
      en_ff <= '0;
    else if (state_ff == ST_SEQ)
      en_ff <= en_ff | slot_hit;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      sys_reset_n_ff <= 1'b0;
    else
      sys_reset_n_ff <= (nxt_state == ST_ACTIVE) || (nxt_state == ST_HIB);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || going_off)
    begin
      chip_on_ff <= LP_CHIP_ON_RST;
      hold_sel_ff <= LP_HOLD_SEL_RST;
      pol_ff <= LP_POL_RST;
    end
    else
    begin
      if ((state_ff == ST_OFF) && start_ok)
        chip_on_ff <= 1'b1;
      else if (wr_ctrl && (state_ff != ST_OFF))
        chip_on_ff <= i_wdata[LP_CTRL_ON_BIT];
      if (wr_ctrl)
      begin
        hold_sel_ff <= i_wdata[LP_CTRL_HOLD_BIT];
        pol_ff <= i_wdata[LP_CTRL_POL_BIT];
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || going_off)
      cfg_ff <= LP_CFG_RST;
    else if (wr_cfg)
      cfg_ff <= i_wdata[LP_CFG_W-1:0];
    else if ((state_ff == ST_HIB) && start_ok)
      cfg_ff[LP_CFG_HIB] <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || going_off)
      mask_ff <= LP_MASK_RST;
    else if (i_wr && (i_addr == LP_REG_MASK))
      mask_ff <= i_wdata[LP_ST_W-1:0];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || going_off)
    begin
      sel_bat_ff <= 1'b0;
      sel_usb_ff <= 1'b0;
      trickle_ff <= 1'b0;
    end
    else if ((state_ff == ST_OFF || state_ff == ST_HIB) && start_ok && ev_usb)
    begin
      sel_bat_ff <= cfg_ff[LP_CFG_USB_SUSP];
      sel_usb_ff <= !cfg_ff[LP_CFG_USB_SUSP];
      trickle_ff <= !cfg_ff[LP_CFG_USB_SUSP];
    end
  end

  assign set_v[LP_ST_OFF] = (state_ff == ST_OFF) && start_ok;
  assign set_v[LP_ST_HIB] = (state_ff == ST_HIB) && start_ok;
  assign set_v[LP_ST_CONV] = i_conv_fault_reset && !conv_d_ff;
  assign set_v[LP_ST_WDOG] = i_wdog_reset && !wdog_d_ff;
  assign set_v[LP_ST_UP] = u_trg[LP_TRG_UP].fire;
  assign set_v[LP_ST_BTN] = u_trg[LP_TRG_BTN].fire;
  assign set_v[LP_ST_WAKE] = u_trg[LP_TRG_WAKE].fire;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      status_ff <= '0;
    else
      status_ff <= (rd_status ? '0 : status_ff) | set_v;
  end

  assign o_wake_first_level_irq = |(status_ff & ~mask_ff);

  assign slot_idx = LP_SLOT_W'(i_addr - LP_REG_SLOT0);

  always_comb
  begin
    rd_val = '0;
    case (i_addr)
      LP_REG_CTRL:
      begin
        rd_val[LP_CTRL_ON_BIT] = chip_on_ff;
        rd_val[LP_CTRL_HOLD_BIT] = hold_sel_ff;
        rd_val[LP_CTRL_POL_BIT] = pol_ff;
      end
      LP_REG_STATUS:
        rd_val = LP_DATA_W'(status_ff);
      LP_REG_MASK:
        rd_val = LP_DATA_W'(mask_ff);
      LP_REG_CFG:
        rd_val = LP_DATA_W'(cfg_ff);
      LP_REG_STATE:
        rd_val = LP_DATA_W'({slot_ff, state_ff});
      default:
        if ((i_addr >= LP_REG_SLOT0) && (i_addr < LP_REG_SLOT0 + LP_NUM_SUPPLY))
          rd_val = LP_DATA_W'(slot_tab_ff[slot_idx]);
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      rdata_ff <= '0;
    else if (i_rd)
      rdata_ff <= rd_val;
    else
      rdata_ff <= '0;
  end

  assign o_rdata = rdata_ff;
  assign o_supply_en = en_ff;
  assign o_sel_battery = sel_bat_ff;
  assign o_sel_usb = sel_usb_ff;
  assign o_usb_trickle_100ma = trickle_ff;
  assign o_sys_reset_n = sys_reset_n_ff;
  assign o_power_state = state_ff;

  property p_start;
    @(posedge i_clk_sys) disable iff (!i_nrst) (state_ff == ST_OFF) && start_ok |=> (state_ff == ST_SEQ);
  endproperty
  a_start: assert property (p_start) else $error("Startup event did not start.");

  property p_supply_gate;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (state_ff == ST_OFF) && !i_supply_above_threshold |=> (state_ff == ST_OFF);
  endproperty
  a_supply_gate: assert property (p_supply_gate) else $error("Started below threshold.");

  property p_stop_first;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (state_ff != ST_OFF) && stop_ev |=> (state_ff == ST_OFF) && !chip_on_ff && pol_ff && (en_ff == '0);
  endproperty
  a_stop_first: assert property (p_stop_first) else $error("Shutdown did not reach OFF.");

  property p_on_bit;
    @(posedge i_clk_sys) disable iff (!i_nrst) (state_ff == ST_OFF) && start_ok |=> chip_on_ff && status_ff[LP_ST_OFF];
  endproperty
  a_on_bit: assert property (p_on_bit) else $error("Startup left on bit or status clear.");

  property p_clear_on_read;
    @(posedge i_clk_sys) disable iff (!i_nrst) rd_status |=> (status_ff == $past(set_v)) && (o_rdata[6:0] == $past(status_ff));
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("Status read did not clear.");

  property p_irq;
    @(posedge i_clk_sys) disable iff (!i_nrst) set_v[LP_ST_BTN] && !mask_ff[LP_ST_BTN] && !going_off |=> o_wake_first_level_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Unmasked cause gave no interrupt.");

  property p_mask_all;
    @(posedge i_clk_sys) disable iff (!i_nrst) (mask_ff == 7'h7f) |-> !o_wake_first_level_irq;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("Masked cause raised interrupt.");

  property p_slot_wait;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (state_ff == ST_SEQ) && ($past(state_ff) == ST_SEQ) && (slot_ff != $past(slot_ff))
        |-> ($past(tmr_ff) >= P_SLOT_CYC) && $past(slot_ok) && (slot_ff == $past(slot_ff) + 4'h1);
  endproperty
  a_slot_wait: assert property (p_slot_wait) else $error("Slot advanced too early.");

  property p_fourteen;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (state_ff == ST_ACTIVE) && ($past(state_ff) == ST_SEQ) |-> ($past(slot_ff) == LP_LAST_SLOT);
  endproperty
  a_fourteen: assert property (p_fourteen) else $error("Active before last slot.");

  property p_wdog;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (state_ff == ST_ACTIVE) && (i_prior_fault_count < 4'h7) && !(stop_ev && !wdog_stop) && !cfg_ff[LP_CFG_HIB]
        |=> (state_ff == ST_ACTIVE);
  endproperty
  a_wdog: assert property (p_wdog) else $error("Watchdog shut down too early.");

  property p_usb;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (state_ff == ST_OFF) && start_ok && ev_usb && !cfg_ff[LP_CFG_USB_SUSP] |=> o_sel_usb && o_usb_trickle_100ma;
  endproperty
  a_usb: assert property (p_usb) else $error("USB start did not select USB power.");

endmodule : psss_ctrl

// ---- verif/psss_supply_model.sv ----
// Far-side supply model: each supply reports 90% good some cycles after its enable.
// Assumes enables come from the controller on the same clock; higher supplies ramp slower.
module psss_supply_model
  import psss_pkg::*;
#(
  parameter int P_RISE_CYC = 3
)
(
  input wire logic i_clk_sys,
  input wire logic [LP_NUM_SUPPLY-1:0] i_supply_en,
  output logic [LP_NUM_SUPPLY-1:0] o_supply_good
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [LP_NUM_SUPPLY];
  always_ff @(posedge i_clk_sys)
  begin
    for (int i = 0; i < LP_NUM_SUPPLY; i++)
    begin
      cnt[i] <= i_supply_en[i] ? cnt[i] + 1 : 0;
      o_supply_good[i] <= i_supply_en[i] && (cnt[i] >= P_RISE_CYC + i);
    end
  end
endmodule : psss_supply_model

// ---- verif/psss_ctrl_tb_top.sv ----
// Self-checking bench for the power-state controller with shortened time counts.
// Assumes the supply model on the far side; triggers are driven as asserted levels.
module psss_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import psss_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_supply_above_threshold = 1'b1;
  logic [3:0] i_prior_fault_count = 4'h0;
  logic [11:0] trg = 12'h000;
  logic [15:0] o_rdata;
  logic [10:0] o_supply_en;
  logic [10:0] good;
  logic o_sel_battery;
  logic o_sel_usb;
  logic o_usb_trickle_100ma;
  logic o_wake_first_level_irq;
  logic o_sys_reset_n;
  logic [1:0] o_power_state;
  logic [15:0] d;
  int failures = 0;
  int cmp_count = 0;

  psss_ctrl #(.P_QUAL_CYC(32'd20), .P_HOLD_LONG_CYC(32'd200), .P_HOLD_SHORT_CYC(32'd100), .P_SLOT_CYC(32'd10))
  psss_ctrl_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_button(~trg[0]), .i_gpio_wake(trg[1]), .i_gpio_power_up_input(trg[2]),
    .i_gpio_power_down_input(trg[3]), .i_rtc_alarm(trg[10]), .i_adaptor_sense(trg[9]), .i_usb_sense(trg[4]),
    .i_supply_above_threshold(i_supply_above_threshold), .i_conv_fault_reset(trg[8]), .i_wdog_reset(trg[11]),
    .i_wdog_timeout(trg[7]), .i_prior_fault_count(i_prior_fault_count), .i_fault_shutdown(trg[6]),
    .i_thermal_shutdown(trg[5]), .i_supply_good(good), .o_supply_en(o_supply_en), .o_sel_battery(o_sel_battery),
    .o_sel_usb(o_sel_usb), .o_usb_trickle_100ma(o_usb_trickle_100ma),
    .o_wake_first_level_irq(o_wake_first_level_irq), .o_sys_reset_n(o_sys_reset_n), .o_power_state(o_power_state));

  psss_supply_model psss_supply_model_inst (.i_clk_sys(i_clk_sys), .i_supply_en(o_supply_en), .o_supply_good(good));

  initial
  begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  task automatic pulse(input int k, input int n);
    @(posedge i_clk_sys);
    trg[k] <= 1'b1;
    repeat (n) @(posedge i_clk_sys);
    trg[k] <= 1'b0;
  endtask : pulse

  // The state is looked at mid-cycle, away from the edge that updates it; the task returns on a rising edge.
  task automatic wait_st(input logic [1:0] s);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    while (o_power_state !== s && n < 600)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    chk("power_state", {14'h0000, o_power_state}, {14'h0000, s});
    @(posedge i_clk_sys);
  endtask : wait_st

  task automatic t_reset;
    rd(LP_REG_CTRL);
    chk("ctrl", d, 16'h0002);
    rd(LP_REG_MASK);
    chk("mask", d, 16'h0000);
    rd(8'hff);
    chk("unmapped", d, 16'h0000);
  endtask : t_reset

  task automatic t_button;
    pulse(0, 10);
    repeat (30) @(posedge i_clk_sys);
    chk("short press", {14'h0000, o_power_state}, 16'h0000);
    i_supply_above_threshold <= 1'b0;
    pulse(0, 30);
    repeat (5) @(posedge i_clk_sys);
    chk("low supply", {14'h0000, o_power_state}, 16'h0000);
    i_supply_above_threshold <= 1'b1;
    pulse(0, 25);
    wait_st(ST_ACTIVE);
    chk("enables", {5'h00, o_supply_en}, 16'h07ff);
    chk("reset out on", {15'h0000, o_sys_reset_n}, 16'h0001);
    chk("irq", {15'h0000, o_wake_first_level_irq}, 16'h0001);
    rd(LP_REG_STATUS);
    chk("status", d, 16'h0042);
    rd(LP_REG_STATUS);
    chk("status reread", d, 16'h0000);
    rd(LP_REG_CTRL);
    chk("ctrl on", d, 16'h8002);
    wr(LP_REG_CTRL, 16'h0002);
    wait_st(ST_OFF);
    chk("enables off", {5'h00, o_supply_en}, 16'h0000);
    chk("reset out", {15'h0000, o_sys_reset_n}, 16'h0000);
  endtask : t_button

  task automatic t_mask;
    pulse(1, 25);
    wait_st(ST_ACTIVE);
    rd(LP_REG_STATUS);
    chk("status wake", d, 16'h0041);
    wr(LP_REG_MASK, 16'h007f);
    pulse(8, 1);
    repeat (2) @(posedge i_clk_sys);
    chk("masked irq", {15'h0000, o_wake_first_level_irq}, 16'h0000);
    wr(LP_REG_MASK, 16'h0000);
    #1;
    chk("unmasked irq", {15'h0000, o_wake_first_level_irq}, 16'h0001);
    rd(LP_REG_STATUS);
    chk("status fault", d, 16'h0010);
    pulse(3, 25);
    wait_st(ST_OFF);
  endtask : t_mask

  task automatic t_sources;
    pulse(4, 5);
    wait_st(ST_ACTIVE);
    chk("usb power", {14'h0000, o_sel_usb, o_usb_trickle_100ma}, 16'h0003);
    pulse(5, 1);
    wait_st(ST_OFF);
    wr(LP_REG_CFG, 16'h0002);
    pulse(4, 5);
    wait_st(ST_ACTIVE);
    chk("battery power", {15'h0000, o_sel_battery}, 16'h0001);
    pulse(6, 1);
    wait_st(ST_OFF);
    pulse(9, 3);
    wait_st(ST_ACTIVE);
    i_prior_fault_count <= 4'h6;
    pulse(7, 3);
    repeat (3) @(posedge i_clk_sys);
    chk("wdog six", {14'h0000, o_power_state}, 16'h0002);
    i_prior_fault_count <= 4'h7;
    pulse(7, 1);
    wait_st(ST_OFF);
  endtask : t_sources

  task automatic t_hold;
    pulse(2, 25);
    wait_st(ST_ACTIVE);
    rd(LP_REG_STATUS);
    chk("status up", d, 16'h0044);
    wr(LP_REG_CTRL, 16'h800a);
    pulse(0, 110);
    wait_st(ST_OFF);
  endtask : t_hold

  // The button press of the hold scenario is still recorded in status bit 1 here.
  task automatic t_alarm;
    pulse(10, 3);
    repeat (5) @(posedge i_clk_sys);
    chk("alarm disabled", {14'h0000, o_power_state}, 16'h0000);
    wr(LP_REG_CFG, 16'h0001);
    pulse(10, 3);
    wait_st(ST_ACTIVE);
    pulse(11, 1);
    repeat (2) @(posedge i_clk_sys);
    rd(LP_REG_STATUS);
    chk("status wdog", d, 16'h004a);
    wr(LP_REG_CTRL, 16'h0002);
    wait_st(ST_OFF);
  endtask : t_alarm

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    failures++;
    finish_test();
  end

  initial
  begin
    repeat (5) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    t_reset();
    t_button();
    t_mask();
    t_sources();
    t_hold();
    t_alarm();
    finish_test();
  end
endmodule : psss_ctrl_tb_top
